// [core/dsl_pkg.sv]
// shared constants for the serial range loader link, device end and host end
package dsl_pkg;
	// frame layout: command field sits just above the ignored nibble and the data word
	localparam int FRAME_BITS = 32;
	localparam int SHORT_FRAME_BITS = 24;
	localparam int DATA_BITS = 16;
	localparam int CMD_MSB = 23;
	localparam int CMD_LSB = 20;
	localparam int CNT_W = 6;
	localparam logic [CNT_W-1:0] CNT_MAX = 6'h3f;
	localparam logic [CNT_W-1:0] CNT_SHORT = 6'h18;
	localparam logic [CNT_W-1:0] CNT_LONG = 6'h20;

	// command field codes
	localparam logic [3:0] CMD_LOAD_INPUT = 4'h0;
	localparam logic [3:0] CMD_UPDATE = 4'h1;
	localparam logic [3:0] CMD_LOAD_BOTH = 4'h2;
	localparam logic [3:0] CMD_RANGE_U5 = 4'h8;
	localparam logic [3:0] CMD_RANGE_U10 = 4'h9;
	localparam logic [3:0] CMD_RANGE_B5 = 4'ha;
	localparam logic [3:0] CMD_RANGE_B10 = 4'hb;
	localparam logic [3:0] CMD_RANGE_B2P5 = 4'hc;
	localparam logic [3:0] CMD_RANGE_OFS = 4'hd;
	localparam logic [3:0] CMD_NOP = 4'hf;
	localparam logic [3:0] RANGE_RESET = CMD_RANGE_U5;
	localparam logic [15:0] WORD_RESET = 16'h0000;

	// timing of the host end
	localparam int CLK_PERIOD_PS = 25000;
	localparam int SCK_HALF_NS = 125;
	localparam int CS_HIGH_NS = 360;
	localparam int CLR_LOW_NS = 100;
	localparam int SCK_HALF_CYC = (SCK_HALF_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	localparam int CS_HIGH_CYC = (CS_HIGH_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	localparam int CLR_LOW_CYC = (CLR_LOW_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;

	// host register map on the wishbone side (byte addresses)
	localparam int WB_AW = 8;
	localparam logic [7:0] ADDR_CTRL = 8'h00;
	localparam logic [7:0] ADDR_DATA = 8'h04;
	localparam logic [7:0] ADDR_STATUS = 8'h08;
	localparam logic [7:0] ADDR_RX = 8'h0c;
	localparam int CTRL_CMD_LSB = 0;
	localparam int CTRL_LONG_BIT = 4;
	localparam int CTRL_START_BIT = 8;
	localparam int CTRL_CLEAR_BIT = 9;
	localparam int STAT_BUSY_BIT = 0;
	localparam int STAT_CLEAR_BIT = 1;
endpackage

// [core/dsl_link_if.sv]
// four-wire serial link (sck, sdi, strobe, sdo) plus clear between the host end and the converter end
`timescale 1ns/1ps
interface dsl_link_if;
	logic sck;
	logic sdi;
	logic select_load_strobe_n;
	logic async_zero_clear_n;
	logic sdo;
	modport dev (
		input sck,
		input sdi,
		input select_load_strobe_n,
		input async_zero_clear_n,
		output sdo
	);
	modport host (
		output sck,
		output sdi,
		output select_load_strobe_n,
		output async_zero_clear_n,
		input sdo
	);
endinterface // dsl_link_if

// [core/dsl_device.sv]
// converter end: serial shift register, command decode, buffers and range
//
// Overview of operation
// - shift SDI on SCK rise while strobe low
// - SDO changes with SCK rising edge
// - strobe rise stops shifting, runs command field
// - clear low returns all registers to power-on values at once
// - 0000 loads data word into input buffer
// - 0001 copies input buffer to converter buffer
// - 0010 loads data into both buffers
// - range codes load both buffers, set range
// - data word is last sixteen bits shifted
// - host sends command, four ignored, sixteen data
// - low data bits ignored for narrower variants
// - long frame has eight leading ignored bits
// - 32-bit shift register, SDO flop loads last stage at each rise
// - daisy chain shares clock and strobe
// - reset gives 0-5V range and zero code
// - update after clear keeps zero output
// - clear right after strobe needs range resend
// - range change sent with its data word
`timescale 1ns/1ps
module dsl_device
	import dsl_pkg::*;
#(
	parameter int RES_BITS = 12
) (
	input wire logic clk,
	input wire logic rst_b,
	dsl_link_if.dev link,
	output logic [RES_BITS-1:0] converter_word,
	output logic [15:0] input_word,
	output logic [3:0] range_code,
	output logic update_pulse,
	output logic reserved_pulse,
	output logic short_frame_pulse
);
	generate
		if (RES_BITS != 12 && RES_BITS != 14 && RES_BITS != 16) begin : g_bad_res
			$error("dsl_device: RES_BITS must be 12, 14 or 16");
		end
	endgenerate

	// command field and frame counts must describe the same frame layout
	generate
		if (CMD_MSB != SHORT_FRAME_BITS - 1 || CMD_LSB != CMD_MSB - 3
			|| int'(CNT_SHORT) != SHORT_FRAME_BITS || int'(CNT_LONG) != FRAME_BITS) begin : g_bad_frame
			$error("dsl_device: frame layout constants disagree");
		end
	endgenerate

	typedef struct packed {
		logic sck_s1;
		logic sck_s2;
		logic sck_s3;
		logic sdi_s1;
		logic sdi_s2;
		logic cs_s1;
		logic cs_s2;
		logic cs_s3;
		logic [FRAME_BITS-1:0] input_shift_reg;
		logic [CNT_W-1:0] bit_cnt;
		logic sdo;
		logic [DATA_BITS-1:0] input_buffer;
		logic [DATA_BITS-1:0] converter_buffer;
		logic [3:0] range;
		logic update;
		logic reserved;
		logic short_frame;
	} dsl_dev_state_t;

	localparam dsl_dev_state_t STATE_RESET = '{
		sck_s1: 1'b0,
		sck_s2: 1'b0,
		sck_s3: 1'b0,
		sdi_s1: 1'b0,
		sdi_s2: 1'b0,
		cs_s1: 1'b1,
		cs_s2: 1'b1,
		cs_s3: 1'b1,
		input_shift_reg: '0,
		bit_cnt: '0,
		sdo: 1'b0,
		input_buffer: WORD_RESET,
		converter_buffer: WORD_RESET,
		range: RANGE_RESET,
		update: 1'b0,
		reserved: 1'b0,
		short_frame: 1'b0
	};

	// narrower variants see their unused low data bits as zero
	function automatic logic [DATA_BITS-1:0] trim_word(input logic [DATA_BITS-1:0] w);
		logic [DATA_BITS-1:0] mask;
		mask = {DATA_BITS{1'b1}} << (DATA_BITS - RES_BITS);
		return w & mask;
	endfunction

	// codes that load the shift register word into both buffers
	function automatic logic loads_both(input logic [3:0] c);
		return (c == CMD_LOAD_BOTH) || (c[3] && (c[2:0] <= CMD_RANGE_OFS[2:0]));
	endfunction

	// codes that also select a new output range
	function automatic logic sets_range(input logic [3:0] c);
		return c[3] && (c[2:0] <= CMD_RANGE_OFS[2:0]);
	endfunction

	dsl_dev_state_t q;
	dsl_dev_state_t n;
	logic arst_b;
	logic sck_rise;
	logic cs_low;
	logic cs_rise;
	logic [3:0] command_field;
	logic [DATA_BITS-1:0] data_word;

	// clear acts without the clock, like power-on reset
	assign arst_b = rst_b & link.async_zero_clear_n;

	assign sck_rise = q.sck_s2 & ~q.sck_s3;
	assign cs_low = ~q.cs_s2;
	assign cs_rise = q.cs_s2 & ~q.cs_s3;
	// the command field sits at a fixed distance from the frame end in both frame lengths
	assign command_field = q.input_shift_reg[CMD_MSB:CMD_LSB];
	assign data_word = trim_word(q.input_shift_reg[DATA_BITS-1:0]);

	always_comb begin
		n = q;
		// two flops before any logic reads sck, sdi or strobe (clear goes straight to the reset); the third only marks edges
		n.sck_s1 = link.sck;
		n.sck_s2 = q.sck_s1;
		n.sck_s3 = q.sck_s2;
		n.sdi_s1 = link.sdi;
		n.sdi_s2 = q.sdi_s1;
		n.cs_s1 = link.select_load_strobe_n;
		n.cs_s2 = q.cs_s1;
		n.cs_s3 = q.cs_s2;
		n.update = 1'b0;
		n.reserved = 1'b0;
		n.short_frame = 1'b0;

		// shifting only while the strobe is low
		if (cs_low && sck_rise) begin
			n.input_shift_reg = {q.input_shift_reg[FRAME_BITS-2:0], q.sdi_s2};
			// sdo shows the stage that leaves the register at this rise
			n.sdo = q.input_shift_reg[FRAME_BITS-1];
			if (q.bit_cnt != CNT_MAX) begin
				n.bit_cnt = q.bit_cnt + 1'b1;
			end
		end

		// strobe rise ends the frame and runs the command
		if (cs_rise) begin
			n.bit_cnt = '0;
			if (q.bit_cnt < CNT_SHORT) begin
				// too few bits to hold command and data: nothing is executed
				n.short_frame = 1'b1;
			end else begin
				// frame long enough: decode the command field
				case (command_field)
					CMD_LOAD_INPUT: begin
						n.input_buffer = data_word;
					end
					CMD_UPDATE: begin
						n.converter_buffer = q.input_buffer;
						n.update = 1'b1;
					end
					CMD_NOP: begin
						n.input_buffer = q.input_buffer;
					end
					default: begin
						if (loads_both(command_field)) begin
							n.input_buffer = data_word;
							n.converter_buffer = data_word;
							n.update = 1'b1;
							if (sets_range(command_field)) begin
								n.range = command_field;
							end
						end else begin
							// reserved codes leave every buffer untouched
							n.reserved = 1'b1;
						end
					end
				endcase
			end
		end
	end

	// clear low holds every register at its power-on value, even mid-frame
	always_ff @(posedge clk or negedge arst_b) begin
		if (!arst_b) begin
			q <= STATE_RESET;
		end else begin
			q <= n;
		end
	end

	// outputs come straight from state flops
	assign link.sdo = q.sdo;
	assign converter_word = q.converter_buffer[DATA_BITS-1 -: RES_BITS];
	assign input_word = q.input_buffer;
	assign range_code = q.range;
	assign update_pulse = q.update;
	assign reserved_pulse = q.reserved;
	assign short_frame_pulse = q.short_frame;
endmodule // dsl_device

// [core/dsl_host.sv]
// host end: wishbone registers, frame serialiser, clear pulse and sdo capture
//
// Chosen here: the address map and the Wishbone interface to the registers.
`timescale 1ns/1ps
module dsl_host
	import dsl_pkg::*;
#(
	parameter int HALF_CYC = SCK_HALF_CYC,
	parameter int LOAD_CYC = CS_HIGH_CYC,
	parameter int CLEAR_CYC = CLR_LOW_CYC
) (
	input wire logic clk,
	input wire logic rst_b,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [WB_AW-1:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	dsl_link_if.host link
);
	generate
		if (HALF_CYC < 3 || HALF_CYC > 255 || LOAD_CYC < 1 || LOAD_CYC > 255
			|| CLEAR_CYC < 1 || CLEAR_CYC > 255) begin : g_bad_timing
			$error("dsl_host: timing counts out of range");
		end
	endgenerate

	typedef enum logic [2:0] {
		ST_IDLE,
		ST_LOW,
		ST_HIGH,
		ST_TAIL,
		ST_LOAD,
		ST_CLEAR
	} dsl_host_fsm_t;

	typedef struct packed {
		dsl_host_fsm_t fsm;
		logic [7:0] timer;
		logic [CNT_W-1:0] bits_left;
		logic [FRAME_BITS-1:0] frame;
		logic [FRAME_BITS-1:0] rx;
		logic [3:0] cmd;
		logic long_frame;
		logic [DATA_BITS-1:0] data;
		logic sck;
		logic sdi;
		logic cs_n;
		logic clr_n;
		logic sdo_s1;
		logic sdo_s2;
		logic ack;
		logic [31:0] dat;
	} dsl_host_state_t;

	localparam logic [7:0] HALF_T = 8'(HALF_CYC - 1);
	localparam logic [7:0] LOAD_T = 8'(LOAD_CYC - 1);
	localparam logic [7:0] CLEAR_T = 8'(CLEAR_CYC - 1);

	dsl_host_state_t q;
	dsl_host_state_t n;
	logic access;
	logic wr_now;

	assign access = wb_cyc_i & wb_stb_i;
	// a write takes effect at the edge where ack is seen high
	assign wr_now = access & wb_we_i & q.ack;

	always_comb begin
		n = q;
		n.sdo_s1 = link.sdo;
		n.sdo_s2 = q.sdo_s1;
		n.ack = access & ~q.ack;
		if (access && !q.ack) begin
			case (wb_adr_i)
				ADDR_CTRL: n.dat = {27'h0, q.long_frame, q.cmd};
				ADDR_DATA: n.dat = {16'h0, q.data};
				ADDR_STATUS: n.dat = {30'h0, ~q.clr_n, q.fsm != ST_IDLE};
				ADDR_RX: n.dat = q.rx;
				default: n.dat = 32'h0;
			endcase
		end
		if (wr_now && wb_adr_i == ADDR_DATA) begin
			if (wb_sel_i[0]) n.data[7:0] = wb_dat_i[7:0];
			if (wb_sel_i[1]) n.data[15:8] = wb_dat_i[15:8];
		end
		if (q.timer != 8'h00) begin
			n.timer = q.timer - 8'h01;
		end
		case (q.fsm)
			ST_IDLE: begin
				if (wr_now && wb_adr_i == ADDR_CTRL && wb_sel_i[0]) begin
					n.cmd = wb_dat_i[CTRL_CMD_LSB +: 4];
					n.long_frame = wb_dat_i[CTRL_LONG_BIT];
				end
				if (wr_now && wb_adr_i == ADDR_CTRL && wb_sel_i[1]) begin
					// clear only from idle, so never inside the load window after a strobe
					if (wb_dat_i[CTRL_CLEAR_BIT]) begin
						n.clr_n = 1'b0;
						n.timer = CLEAR_T;
						n.fsm = ST_CLEAR;
					end else if (wb_dat_i[CTRL_START_BIT]) begin
						// command and data travel in one frame, msb first
						if (wb_sel_i[0] ? wb_dat_i[CTRL_LONG_BIT] : q.long_frame) begin
							n.frame = {8'h00, n.cmd, 4'h0, q.data};
							n.bits_left = CNT_LONG;
						end else begin
							n.frame = {n.cmd, 4'h0, q.data, 8'h00};
							n.bits_left = CNT_SHORT;
						end
						n.cs_n = 1'b0;
						n.sdi = n.frame[FRAME_BITS-1];
						n.timer = HALF_T;
						n.fsm = ST_LOW;
					end
				end
			end
			ST_LOW: begin
				if (q.timer == 8'h00) begin
					n.sck = 1'b1;
					n.rx = {q.rx[FRAME_BITS-2:0], q.sdo_s2};
					n.timer = HALF_T;
					n.fsm = ST_HIGH;
				end
			end
			ST_HIGH: begin
				if (q.timer == 8'h00) begin
					n.sck = 1'b0;
					n.bits_left = q.bits_left - 1'b1;
					n.frame = {q.frame[FRAME_BITS-2:0], 1'b0};
					n.sdi = q.frame[FRAME_BITS-2];
					n.timer = HALF_T;
					n.fsm = (q.bits_left == 6'h01) ? ST_TAIL : ST_LOW;
				end
			end
			ST_TAIL: begin
				if (q.timer == 8'h00) begin
					n.cs_n = 1'b1;
					n.timer = LOAD_T;
					n.fsm = ST_LOAD;
				end
			end
			ST_LOAD: begin
				if (q.timer == 8'h00) begin
					n.fsm = ST_IDLE;
				end
			end
			ST_CLEAR: begin
				if (q.timer == 8'h00) begin
					n.clr_n = 1'b1;
					n.fsm = ST_IDLE;
				end
			end
			default: begin
				n.fsm = ST_IDLE;
			end
		endcase
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			q <= '{fsm: ST_IDLE, timer: 8'h00, bits_left: '0, frame: '0, rx: '0,
				cmd: CMD_NOP, long_frame: 1'b0, data: WORD_RESET, sck: 1'b0,
				sdi: 1'b0, cs_n: 1'b1, clr_n: 1'b1, sdo_s1: 1'b0, sdo_s2: 1'b0,
				ack: 1'b0, dat: 32'h0};
		end else begin
			q <= n;
		end
	end

	assign link.sck = q.sck;
	assign link.sdi = q.sdi;
	assign link.select_load_strobe_n = q.cs_n;
	assign link.async_zero_clear_n = q.clr_n;
	assign wb_ack_o = q.ack;
	assign wb_dat_o = q.dat;
endmodule // dsl_host

// [tb/dsl_link_asserts.sv]
// link checker: host framing timing and device shift behaviour on the serial wires
`timescale 1ns/1ps
module dsl_link_asserts (
	input wire logic clk,
	input wire logic rst_b,
	input wire logic sck,
	input wire logic sdi,
	input wire logic select_load_strobe_n,
	input wire logic async_zero_clear_n,
	input wire logic sdo
);
	typedef struct packed {
		logic sck_q;
		logic cs_q;
		logic [5:0] cnt;
		logic [31:0] shadow;
	} dsl_chk_t;
	dsl_chk_t st_reg;
	dsl_chk_t st_next;
	logic sck_rise;
	assign sck_rise = sck && !st_reg.sck_q && !select_load_strobe_n;
	// shadow copy of the device shift chain, cleared like the device
	always_comb begin
		st_next = st_reg;
		st_next.sck_q = sck;
		st_next.cs_q = select_load_strobe_n;
		if (!select_load_strobe_n && st_reg.cs_q) begin
			st_next.cnt = 6'h00;
		end
		if (sck_rise) begin
			st_next.cnt = st_reg.cnt + 6'h01;
			st_next.shadow = {st_reg.shadow[30:0], sdi};
		end
		if (!async_zero_clear_n) begin
			st_next.shadow = 32'h0000_0000;
		end
	end
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			st_reg <= '0;
		end else begin
			st_reg <= st_next;
		end
	end
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_b);
	sequence s_clr_low;
		!async_zero_clear_n [*4];
	endsequence
	sequence s_load_gap;
		select_load_strobe_n [*8] ##1 select_load_strobe_n [*7];
	endsequence
	a_sck_idle_low: assert property (select_load_strobe_n |-> !sck)
		else $error("sck high outside a frame");
	a_sdi_held_high: assert property (sck |-> $stable(sdi))
		else $error("sdi moved while sck high");
	a_sdo_on_sck: assert property ($changed(sdo) && async_zero_clear_n |-> sck)
		else $error("sdo moved without an sck rise");
	a_sdo_delay_32: assert property (sck_rise |-> ##4 (sdo == $past(st_reg.shadow[31], 4)))
		else $error("sdo is not the bit from 32 rises earlier");
	a_load_gap: assert property ($rose(select_load_strobe_n) |-> s_load_gap)
		else $error("strobe high time too short");
	a_load_after_sck: assert property ($rose(select_load_strobe_n) |-> !sck && $past(!sck, 4))
		else $error("strobe rose too close to sck");
	a_frame_length: assert property ($rose(select_load_strobe_n) |->
		(st_reg.cnt == 6'h18 || st_reg.cnt == 6'h20))
		else $error("frame is neither 24 nor 32 bits");
	a_clear_width: assert property ($fell(async_zero_clear_n) |->
		s_clr_low ##[1:4] async_zero_clear_n)
		else $error("clear pulse width wrong");
	a_clear_idle: assert property (!async_zero_clear_n |-> select_load_strobe_n && !sck)
		else $error("clear during a frame");
endmodule // dsl_link_asserts

// [tb/dac_serial_range_loader_tb_top.sv]
// self-checking bench: host end drives the converter end over the serial link
`timescale 1ns/1ps
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin n_errors++; \
	$display("[FAIL] %0t got %h want %h", $time, a, b); end end
module dac_serial_range_loader_tb_top;
	import dsl_pkg::*;
	logic clk = 1'b0;
	logic rst_b = 1'b0;
	logic cyc = 1'b0;
	logic stb = 1'b0;
	logic we = 1'b0;
	logic [7:0] adr = 8'h00;
	logic [31:0] dat = 32'h0;
	logic [31:0] dat_o;
	logic ack;
	logic [31:0] rd;
	logic [11:0] cw;
	logic [15:0] iw;
	logic [3:0] rc;
	logic upd_p;
	logic rsv_p;
	logic shf_p;
	int n_upd = 0;
	int n_rsv = 0;
	int n_shf = 0;
	int n_errors = 0;
	int checks = 0;
	dsl_link_if link ();
	dsl_host dsl_host_i (.clk(clk), .rst_b(rst_b), .wb_cyc_i(cyc), .wb_stb_i(stb),
		.wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(dat), .wb_dat_o(dat_o),
		.wb_ack_o(ack), .link(link));
	dsl_device dsl_device_i (.clk(clk), .rst_b(rst_b), .link(link), .converter_word(cw),
		.input_word(iw), .range_code(rc), .update_pulse(upd_p), .reserved_pulse(rsv_p),
		.short_frame_pulse(shf_p));
	dsl_link_asserts dsl_link_asserts_i (.clk(clk), .rst_b(rst_b), .sck(link.sck),
		.sdi(link.sdi), .select_load_strobe_n(link.select_load_strobe_n),
		.async_zero_clear_n(link.async_zero_clear_n), .sdo(link.sdo));
	always #12.5 clk = ~clk;
	// count the one-cycle pulses of the converter end
	always @(posedge clk) begin
		if (upd_p === 1'b1) n_upd <= n_upd + 1;
		if (rsv_p === 1'b1) n_rsv <= n_rsv + 1;
		if (shf_p === 1'b1) n_shf <= n_shf + 1;
	end
	task automatic tally_and_finish();
		$display("errors %0d checks %0d", n_errors, checks);
		if (n_errors == 0 && checks > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask
	task automatic fail_out(input string m);
		n_errors++;
		$display("[FAIL] %0t %s", $time, m);
		tally_and_finish();
	endtask
	task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		@(posedge clk);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		dat <= d;
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (ack !== 1'b1 && n < 20);
		rd = dat_o;
		cyc <= 1'b0;
		stb <= 1'b0;
		we <= 1'b0;
		if (ack !== 1'b1) fail_out("no ack");
	endtask
	task automatic wait_idle();
		int n;
		n = 0;
		repeat (2) @(posedge clk);
		do begin
			wb(1'b0, ADDR_STATUS, 32'h0);
			n++;
		end while (rd[1:0] !== 2'b00 && n < 400);
		if (rd[1:0] !== 2'b00) fail_out("link stays busy");
	endtask
	task automatic send(input logic [3:0] c, input logic [15:0] d, input logic lng);
		wb(1'b1, ADDR_DATA, {16'h0000, d});
		wb(1'b1, ADDR_CTRL, {22'h0, 2'b01, 3'h0, lng, c});
		wait_idle();
	endtask
	task automatic expect_state(input logic [15:0] b1, input logic [15:0] b2, input logic [3:0] r);
		`CHK(iw, {b1[15:4], 4'h0})
		`CHK(cw, b2[15:4])
		`CHK(rc, r)
	endtask
	task automatic sc_power_on();
		expect_state(16'h0, 16'h0, 4'h8);
	endtask
	task automatic sc_load_input();
		send(CMD_LOAD_INPUT, 16'h1234, 1'b0);
		expect_state(16'h1234, 16'h0, 4'h8);
	endtask
	task automatic sc_update();
		logic [31:0] f;
		int u0;
		f = {8'h00, CMD_UPDATE, 4'h0, 16'hffff};
		u0 = n_upd;
		send(CMD_UPDATE, 16'hffff, 1'b1);
		expect_state(16'h1234, 16'h1234, 4'h8);
		`CHK(n_upd - u0, 1)
		send(CMD_NOP, 16'h0000, 1'b1);
		wb(1'b0, ADDR_RX, 32'h0);
		`CHK(rd[30:0], f[31:1])
		expect_state(16'h1234, 16'h1234, 4'h8);
	endtask
	task automatic sc_ranges();
		logic [3:0] c;
		logic [15:0] d;
		for (int i = 0; i < 6; i++) begin
			c = CMD_RANGE_U5 + 4'(i);
			d = 16'h0ff1 << i;
			send(c, d, i[0]);
			expect_state(d, d, c);
		end
	endtask
	task automatic sc_load_both();
		send(CMD_LOAD_BOTH, 16'hfedc, 1'b1);
		expect_state(16'hfedc, 16'hfedc, CMD_RANGE_OFS);
	endtask
	task automatic sc_nop_reserved();
		logic [3:0] codes [4] = '{4'hf, 4'h3, 4'h7, 4'he};
		int r0;
		r0 = n_rsv;
		foreach (codes[k]) begin
			send(codes[k], 16'h5a5a, k[0]);
			expect_state(16'hfedc, 16'hfedc, CMD_RANGE_OFS);
		end
		`CHK(n_rsv - r0, 3)
	endtask
	task automatic sc_clear();
		wb(1'b1, ADDR_CTRL, {22'h0, 2'b10, 8'h00});
		wait_idle();
		expect_state(16'h0, 16'h0, 4'h8);
		send(CMD_UPDATE, 16'hffff, 1'b0);
		expect_state(16'h0, 16'h0, 4'h8);
		send(CMD_RANGE_B5, 16'h8000, 1'b0);
		expect_state(16'h8000, 16'h8000, CMD_RANGE_B5);
		`CHK(n_shf, 0)
	endtask
	initial begin
		repeat (20) @(posedge clk);
		rst_b <= 1'b1;
		repeat (4) @(posedge clk);
		sc_power_on();
		sc_load_input();
		sc_update();
		sc_ranges();
		sc_load_both();
		sc_nop_reserved();
		sc_clear();
		tally_and_finish();
	end
endmodule // dac_serial_range_loader_tb_top
